/* hw/qamc_regs.sv */
module qamc_regs
    import qamc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int SAMPLE_W = 14
)
(
    // system clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // serial configuration port
    input wire logic cfg_sck,
    input wire logic cfg_cs_n,
    input wire logic cfg_sdi,
    output logic cfg_sdo_out,
    output logic cfg_sdo_oe,
    // sample path
    input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_in,
    input wire logic [7:0] pattern_lower_bits,
    output logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_out,
    // decoded mode controls
    output qamc_mode_s mode
);

    // link side (cfg_sck domain)
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic rd_flag_r;
    logic [6:0] rd_addr_r;
    logic wr_tgl_r;
    qamc_frame_s wr_word_r;
    logic [23:0] rb_meta_r;
    logic [23:0] rb_sync_r;
    logic [7:0] rd_byte;
    logic sdo_oe_r;

    // system side
    logic wr_tgl_meta_r;
    logic wr_tgl_sync_r;
    logic wr_tgl_seen_r;
    logic wr_apply;
    logic swr_apply;
    logic [7:0] fmt_r;
    logic [7:0] out_r;
    logic [7:0] tp_r;
    logic [23:0] rb_src_r;
    logic [3:0] sleep_cnt_r;
    logic [3:0] swr_quiet_r;
    logic sdo_out_r;
    qamc_mode_s mode_r;
    qamc_mode_s mode_nxt;
    logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_r;

    always_ff @(posedge cfg_sck or posedge cfg_cs_n)
    begin
        if (cfg_cs_n)
        begin
            bit_cnt_r <= 5'h00;
            shift_r <= 16'h0000;
            rd_flag_r <= 1'b0;
            rd_addr_r <= 7'h00;
        end
        else if (bit_cnt_r != FRAME_BITS)
        begin
            shift_r <= {shift_r[14:0], cfg_sdi};
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == HDR_BITS - 5'h01)
            begin
                rd_flag_r <= shift_r[6];
                rd_addr_r <= {shift_r[5:0], cfg_sdi};
            end
        end
    end

    always_ff @(posedge cfg_sck or posedge reset)
    begin
        if (reset)
        begin
            wr_tgl_r <= 1'b0;
            wr_word_r <= '0;
        end
        else if (bit_cnt_r == FRAME_BITS - 5'h01 && !shift_r[14])
        begin
            wr_word_r <= {shift_r[14:0], cfg_sdi};
            wr_tgl_r <= ~wr_tgl_r;
        end
    end

    // register values only change after a frame ends, so long settled here
    always_ff @(posedge cfg_sck)
    begin
        rb_meta_r <= rb_src_r;
        rb_sync_r <= rb_meta_r;
    end

    always_comb
    begin
        unique case (rd_addr_r)
            ADDR_FORMAT: rd_byte = rb_sync_r[7:0];
            ADDR_OUTPUT: rd_byte = rb_sync_r[15:8];
            ADDR_PATTERN: rd_byte = rb_sync_r[23:16];
            default: rd_byte = 8'h00;
        endcase
    end

    // read data out, msb first, open drain
    always_ff @(negedge cfg_sck or posedge cfg_cs_n)
    begin
        if (cfg_cs_n)
            sdo_oe_r <= 1'b0;
        else
            sdo_oe_r <= rd_flag_r && bit_cnt_r >= HDR_BITS && bit_cnt_r < FRAME_BITS
                && !rd_byte[~bit_cnt_r[2:0]];
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_tgl_meta_r <= 1'b0;
            wr_tgl_sync_r <= 1'b0;
            wr_tgl_seen_r <= 1'b0;
        end
        else
        begin
            wr_tgl_meta_r <= wr_tgl_r;
            wr_tgl_sync_r <= wr_tgl_meta_r;
            wr_tgl_seen_r <= wr_tgl_sync_r;
        end
    end

    assign wr_apply = wr_tgl_sync_r ^ wr_tgl_seen_r;
    assign swr_apply = wr_apply && wr_word_r.addr == ADDR_SW_RESET && wr_word_r.data[SWR_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (reset || swr_apply)
        begin
            fmt_r <= REG_RESET_VAL;
            out_r <= REG_RESET_VAL;
            tp_r <= REG_RESET_VAL;
        end
        else if (wr_apply)
        begin
            unique case (wr_word_r.addr)
                ADDR_FORMAT: fmt_r <= wr_word_r.data;
                ADDR_OUTPUT: out_r <= wr_word_r.data;
                ADDR_PATTERN: tp_r <= wr_word_r.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rb_src_r <= 24'h000000;
        else
            rb_src_r <= {tp_r, out_r, fmt_r};
    end

    // momentary sleep; reset bit itself never stored
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            sleep_cnt_r <= 4'h0;
        else if (swr_apply)
            sleep_cnt_r <= 4'(SLEEP_PULSE_CYC);
        else if (sleep_cnt_r != 4'h0)
            sleep_cnt_r <= sleep_cnt_r - 4'h1;
    end

    // quiet cycles since a soft reset, for the sleep-end check
    always_ff @(posedge sys_clk)
    begin
        if (reset || wr_apply)
            swr_quiet_r <= {3'h0, swr_apply && !reset};
        else if (swr_quiet_r != 4'h0 && swr_quiet_r != 4'(SLEEP_PULSE_CYC + 4))
            swr_quiet_r <= swr_quiet_r + 4'h1;
    end

    always_comb
    begin
        mode_nxt = '0;
        mode_nxt.duty_stabilizer_disable = fmt_r[FMT_DCS_BIT];
        mode_nxt.output_scramble_enable = fmt_r[FMT_OUTPUT_SCRAMBLE_ENABLE_BIT];
        mode_nxt.signed_format_select = fmt_r[FMT_TWOS_BIT];
        mode_nxt.sleep_active = fmt_r[FMT_SLEEP_BIT] || sleep_cnt_r != 4'h0;
        mode_nxt.chan_power_down = mode_nxt.sleep_active ? 4'hF : fmt_r[3:0];
        mode_nxt.driver_current_select = out_r[OUT_CUR_LSB +: 3];
        mode_nxt.internal_termination_enable = out_r[OUT_TERM_BIT];
        mode_nxt.drive_current_x10ua = out_r[OUT_TERM_BIT]
            ? {CUR_X10UA[out_r[OUT_CUR_LSB +: 3]], 1'b0}
            : {1'b0, CUR_X10UA[out_r[OUT_CUR_LSB +: 3]]};
        mode_nxt.output_drivers_disable = out_r[OUT_OFF_BIT];
        mode_nxt.data_clock_output_enable = !out_r[OUT_OFF_BIT];
        mode_nxt.frame_output_enable = !out_r[OUT_OFF_BIT];
        mode_nxt.lane_mode_valid = 1'b1;
        unique case (out_r[2:0])
            3'h0:
            begin
                mode_nxt.lane_two = 1'b1;
                mode_nxt.serial_bits = 5'h10;
            end
            3'h1:
            begin
                mode_nxt.lane_two = 1'b1;
                mode_nxt.serial_bits = 5'h0E;
            end
            3'h2:
            begin
                mode_nxt.lane_two = 1'b1;
                mode_nxt.serial_bits = 5'h0C;
            end
            3'h5: mode_nxt.serial_bits = 5'h0E;
            3'h6: mode_nxt.serial_bits = 5'h0C;
            3'h7: mode_nxt.serial_bits = 5'h10;
            default: mode_nxt.lane_mode_valid = 1'b0;
        endcase
        mode_nxt.pattern_override_enable = tp_r[TP_EN_BIT];
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            mode_r <= '0;
        else
            mode_r <= mode_nxt;
    end

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        logic [SAMPLE_W-1:0] fmt_v;

        always_comb
        begin
            fmt_v = sample_in[ch];
            if (fmt_r[FMT_TWOS_BIT])
                fmt_v[SAMPLE_W-1] = ~fmt_v[SAMPLE_W-1];
            if (fmt_r[FMT_OUTPUT_SCRAMBLE_ENABLE_BIT])
                fmt_v[SAMPLE_W-1:1] = fmt_v[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){fmt_v[0]}};
        end

        always_ff @(posedge sys_clk)
        begin
            if (reset)
                sample_r[ch] <= '0;
            else if (tp_r[TP_EN_BIT])
                sample_r[ch] <= SAMPLE_W'({tp_r[5:0], pattern_lower_bits});
            else
                sample_r[ch] <= fmt_v;
        end
    end

    // open-drain pin only ever pulls low
    always_ff @(posedge sys_clk)
    begin
        sdo_out_r <= 1'b0;
    end

    assign cfg_sdo_out = sdo_out_r;
    assign cfg_sdo_oe = sdo_oe_r;
    assign mode = mode_r;
    assign sample_out = sample_r;

    property p_swr_clear;
        @(posedge sys_clk) disable iff (reset)
        swr_apply |=> fmt_r == 8'h00 && out_r == 8'h00 && tp_r == 8'h00;
    endproperty
    a_swr_clear: assert property (p_swr_clear) else $error("soft reset left data");

    property p_swr_sleep;
        @(posedge sys_clk) disable iff (reset)
        swr_apply |-> ##2 (mode_r.sleep_active && mode_r.chan_power_down == 4'hF) [*8];
    endproperty
    a_swr_sleep: assert property (p_swr_sleep) else $error("no sleep pulse");

    property p_swr_ends;
        @(posedge sys_clk) disable iff (reset)
        swr_quiet_r == 4'(SLEEP_PULSE_CYC + 4) |-> !fmt_r[FMT_SLEEP_BIT] && !mode_r.sleep_active;
    endproperty
    a_swr_ends: assert property (p_swr_ends) else $error("sleep pulse stuck");

    property p_rst_reg_wo;
        @(posedge sys_clk) disable iff (reset)
        wr_apply && wr_word_r.addr == ADDR_SW_RESET && !wr_word_r.data[SWR_BIT]
            |=> $stable(fmt_r) && $stable(out_r) && $stable(tp_r);
    endproperty
    a_rst_reg_wo: assert property (p_rst_reg_wo) else $error("reset reg stored");

    property p_write_lands;
        @(posedge sys_clk) disable iff (reset)
        wr_apply && wr_word_r.addr == ADDR_FORMAT |=> ##1
            mode_r.output_scramble_enable == $past(wr_word_r.data[FMT_OUTPUT_SCRAMBLE_ENABLE_BIT], 2)
            && mode_r.signed_format_select == $past(wr_word_r.data[FMT_TWOS_BIT], 2);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("format write lost");

    property p_sleep_all;
        @(posedge sys_clk) disable iff (reset)
        fmt_r[FMT_SLEEP_BIT] |=> mode_r.sleep_active && mode_r.chan_power_down == 4'hF;
    endproperty
    a_sleep_all: assert property (p_sleep_all) else $error("sleep not global");

    property p_nap;
        @(posedge sys_clk) disable iff (reset)
        !fmt_r[FMT_SLEEP_BIT] && sleep_cnt_r == 4'h0
            |=> mode_r.chan_power_down == $past(fmt_r[3:0]);
    endproperty
    a_nap: assert property (p_nap) else $error("nap map wrong");

    property p_term_double;
        @(posedge sys_clk) disable iff (reset)
        out_r[OUT_TERM_BIT] && out_r[7:5] == 3'h7 |=> mode_r.drive_current_x10ua == 10'h15E;
    endproperty
    a_term_double: assert property (p_term_double) else $error("current not doubled");

    property p_out_off;
        @(posedge sys_clk) disable iff (reset)
        mode_r.output_drivers_disable
            |-> !mode_r.data_clock_output_enable && !mode_r.frame_output_enable;
    endproperty
    a_out_off: assert property (p_out_off) else $error("clock or frame still driven");

    property p_pattern;
        @(posedge sys_clk) disable iff (reset)
        tp_r[TP_EN_BIT] |=> sample_out[0]
            == SAMPLE_W'({$past(tp_r[5:0]), $past(pattern_lower_bits)});
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern not forced");

endmodule

/* hw/qamc_pkg.sv */
package qamc_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLEEP_PULSE_NS = 200;
    localparam int SLEEP_PULSE_CYC = (SLEEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register addresses
    localparam logic [6:0] ADDR_SW_RESET = 7'h00;
    localparam logic [6:0] ADDR_FORMAT = 7'h01;
    localparam logic [6:0] ADDR_OUTPUT = 7'h02;
    localparam logic [6:0] ADDR_PATTERN = 7'h03;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // serial frame
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HDR_BITS = 5'h08;

    // field positions
    localparam int SWR_BIT = 7;
    localparam int FMT_DCS_BIT = 7;
    localparam int FMT_OUTPUT_SCRAMBLE_ENABLE_BIT = 6;
    localparam int FMT_TWOS_BIT = 5;
    localparam int FMT_SLEEP_BIT = 4;
    localparam int OUT_CUR_LSB = 5;
    localparam int OUT_TERM_BIT = 4;
    localparam int OUT_OFF_BIT = 3;
    localparam int TP_EN_BIT = 7;

    // driver current per select code, units of 10 uA, index 7 first
    localparam logic [7:0][8:0] CUR_X10UA = {
        9'h0AF, 9'h0D2, 9'h0FA, 9'h12C, 9'h000, 9'h1C2, 9'h190, 9'h15E
    };

    typedef struct packed {
        logic rw;
        logic [6:0] addr;
        logic [7:0] data;
    } qamc_frame_s;

    typedef struct packed {
        logic duty_stabilizer_disable;
        logic output_scramble_enable;
        logic signed_format_select;
        logic sleep_active;
        logic [3:0] chan_power_down;
        logic [2:0] driver_current_select;
        logic [9:0] drive_current_x10ua;
        logic internal_termination_enable;
        logic output_drivers_disable;
        logic data_clock_output_enable;
        logic frame_output_enable;
        logic lane_two;
        logic [4:0] serial_bits;
        logic lane_mode_valid;
        logic pattern_override_enable;
    } qamc_mode_s;

endpackage

/* verif/qamc_host_model.sv */
module qamc_host_model
    import qamc_pkg::*;
(
    // serial port to device
    output logic cfg_sck,
    output logic cfg_cs_n,
    output logic cfg_sdi,
    // open-drain return, pulled up
    input wire logic cfg_sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rd_data;

    initial
    begin
        cfg_sck = 1'b0;
        cfg_cs_n = 1'b1;
        cfg_sdi = 1'b0;
        rd_data = 8'h00;
    end

    task automatic xfer(input qamc_frame_s f);
        logic [15:0] bits;
        bits = f;
        #7;
        cfg_cs_n = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            cfg_sdi = bits[15-i];
            #80;
            if (i >= 8)
                rd_data = {rd_data[6:0], !cfg_sdo_oe};
            cfg_sck = 1'b1;
            #80;
            cfg_sck = 1'b0;
        end
        #80;
        cfg_cs_n = 1'b1;
        // released line, do not hold last bit
        cfg_sdi = !cfg_sdi;
    endtask
endmodule

/* verif/qamc_regs_tb_top.sv */
module qamc_regs_tb_top
    import qamc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic cfg_sck;
    logic cfg_cs_n;
    logic cfg_sdi;
    logic cfg_sdo_oe;
    logic cfg_sdo_out;
    logic [3:0][13:0] sample_in = '0;
    logic [7:0] pattern_lower_bits = 8'h00;
    logic [3:0][13:0] sample_out;
    qamc_mode_s mode;
    int mismatches = 0;
    int checks = 0;
    int sleep_cnt = 0;
    int cur_tbl[8] = '{350, 400, 450, 0, 300, 250, 210, 175};
    int bits_tbl[8] = '{16, 14, 12, 0, 0, 14, 12, 16};
    logic [7:0] fmt_tbl[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h1F, 8'h05, 8'h0A};

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
        if (mode.sleep_active === 1'b1)
            sleep_cnt++;

    qamc_regs qamc_regs_i (
        .sys_clk(sys_clk), .reset(reset), .cfg_sck(cfg_sck), .cfg_cs_n(cfg_cs_n),
        .cfg_sdi(cfg_sdi), .cfg_sdo_out(cfg_sdo_out), .cfg_sdo_oe(cfg_sdo_oe),
        .sample_in(sample_in), .pattern_lower_bits(pattern_lower_bits),
        .sample_out(sample_out), .mode(mode)
    );

    qamc_host_model qamc_host_model_i (
        .cfg_sck(cfg_sck), .cfg_cs_n(cfg_cs_n), .cfg_sdi(cfg_sdi), .cfg_sdo_oe(cfg_sdo_oe)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        qamc_host_model_i.xfer({1'b0, a, d});
        repeat (6) @(posedge sys_clk);
    endtask

    // read drives ones on data bits, which must not be stored
    task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
        qamc_host_model_i.xfer({1'b1, a, 8'hFF});
        chk(what, {8'h00, exp}, {8'h00, qamc_host_model_i.rd_data});
    endtask

    function automatic logic [13:0] fmt_exp(input logic [13:0] x, input logic tw, input logic rn);
        logic [13:0] y;
        y = x;
        if (tw)
            y[13] = ~y[13];
        if (rn)
            y[13:1] = y[13:1] ^ {13{y[0]}};
        return y;
    endfunction

    task automatic samp(input logic tw, input logic rn, input logic pe, input logic [13:0] pat);
        @(negedge sys_clk);
        for (int c = 0; c < 4; c++)
            sample_in[c] = 14'h1235 + 14'(c * 14'h0A43);
        @(posedge sys_clk);
        @(negedge sys_clk);
        for (int c = 0; c < 4; c++)
            chk("sample_out", {2'b00, pe ? pat : fmt_exp(sample_in[c], tw, rn)},
                {2'b00, sample_out[c]});
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        for (int a = 1; a < 4; a++)
            rd_chk("reset value", 7'(a), 8'h00);
        chk("lane default", 16'(bits_tbl[0]), 16'(mode.serial_bits));
        $display("test reset done");
        foreach (fmt_tbl[k])
        begin
            wr(ADDR_FORMAT, fmt_tbl[k]);
            chk("stabilizer", 16'(fmt_tbl[k][7]), 16'(mode.duty_stabilizer_disable));
            chk("scramble", 16'(fmt_tbl[k][6]), 16'(mode.output_scramble_enable));
            chk("signed", 16'(fmt_tbl[k][5]), 16'(mode.signed_format_select));
            chk("sleep", 16'(fmt_tbl[k][4]), 16'(mode.sleep_active));
            if (!fmt_tbl[k][4])
                chk("nap", 16'(fmt_tbl[k][3:0]), 16'(mode.chan_power_down));
            else
                chk("sleep all", 16'h000F, 16'(mode.chan_power_down));
            rd_chk("format readback", ADDR_FORMAT, fmt_tbl[k]);
        end
        $display("test format done");
        for (int n = 0; n < 11; n++)
        begin
            // termination only with the three lowest currents
            wr(ADDR_OUTPUT, {3'(n < 8 ? n : n - 3), n >= 8, 4'h0});
            chk("current", 16'(cur_tbl[n < 8 ? n : n - 3] * (n >= 8 ? 2 : 1)),
                16'(mode.drive_current_x10ua));
            chk("termination", 16'(n >= 8), 16'(mode.internal_termination_enable));
            chk("current sel", 16'(n < 8 ? n : n - 3), 16'(mode.driver_current_select));
        end
        for (int m = 0; m < 8; m++)
        begin
            wr(ADDR_OUTPUT, {5'h00, 3'(m)});
            chk("lane valid", 16'(m != 3 && m != 4), 16'(mode.lane_mode_valid));
            if (m != 3 && m != 4)
            begin
                chk("lane two", 16'(m < 3), 16'(mode.lane_two));
                chk("frame bits", 16'(bits_tbl[m]), 16'(mode.serial_bits));
            end
        end
        wr(ADDR_OUTPUT, 8'h08);
        chk("outputs off", 16'h0001, 16'(mode.output_drivers_disable));
        chk("clock drv", 16'h0000, 16'(mode.data_clock_output_enable));
        chk("frame drv", 16'h0000, 16'(mode.frame_output_enable));
        $display("test output mode done");
        wr(ADDR_FORMAT, 8'h60);
        samp(1'b1, 1'b1, 1'b0, 14'h0000);
        pattern_lower_bits = 8'hA5;
        wr(ADDR_PATTERN, 8'h83);
        chk("pattern on", 16'h0001, 16'(mode.pattern_override_enable));
        samp(1'b1, 1'b1, 1'b1, 14'h03A5);
        $display("test sample path done");
        wr(ADDR_OUTPUT, 8'hE1);
        wr(ADDR_SW_RESET, 8'h7F);
        rd_chk("low bits no reset", ADDR_FORMAT, 8'h60);
        rd_chk("reset reg read", ADDR_SW_RESET, 8'h00);
        chk("sdo level", 16'h0000, 16'(cfg_sdo_out));
        sleep_cnt = 0;
        wr(ADDR_SW_RESET, 8'h80);
        repeat (12) @(posedge sys_clk);
        chk("reset sleep", 16'(SLEEP_PULSE_CYC), 16'(sleep_cnt));
        for (int a = 1; a < 4; a++)
            rd_chk("soft reset", 7'(a), 8'h00);
        wr(ADDR_FORMAT, 8'h40);
        rd_chk("after self clear", ADDR_FORMAT, 8'h40);
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule
